// ==== ocpre_core.sv ====
// Preloadable occurrence counter with preset RAM behind an APB slave
`timescale 1ns/100ps
module ocpre_core
  import ocpre_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [OCPRE_ADDR_W-1:0] paddr,
  input  wire logic [OCPRE_DATA_W-1:0] pwdata,
  output logic      [OCPRE_DATA_W-1:0] prdata,
  output logic                         pready,
  output logic                         pslverr,
  output logic                         dual_qualifier_select,
  output logic                         pointer_load_mode_n,
  output logic                         pointer_clock_enable_n,
  output logic                         trigger_status_read,
  output logic      [OCPRE_SENSE_W-1:0] counter_sense_lines,
  output logic      [OCPRE_CNT_W-1:0]  event_count_value,
  output logic      [OCPRE_PTR_W-1:0]  pointer_value
);

  // ==========================================================
  // Address decode
  function automatic logic idx_hit(input logic [OCPRE_ADDR_W-1:0] a, input logic [7:0] idx);
    idx_hit = (a[1:0] == 2'b00) && (a[OCPRE_ADDR_W-1:2] == {2'b00, idx});
  endfunction

  function automatic logic idx_known(input logic [OCPRE_ADDR_W-1:0] a);
    idx_known = idx_hit(a, OCPRE_IDX_PTR_STATUS)  || idx_hit(a, OCPRE_IDX_SENSE)
             || idx_hit(a, OCPRE_IDX_QUAL_CTRL)   || idx_hit(a, OCPRE_IDX_PTR_CLK_CTL)
             || idx_hit(a, OCPRE_IDX_PTR_STROBE)  || idx_hit(a, OCPRE_IDX_RAM_LOW)
             || idx_hit(a, OCPRE_IDX_RAM_HIGH)    || idx_hit(a, OCPRE_IDX_PRESET)
             || idx_hit(a, OCPRE_IDX_COUNT)       || idx_hit(a, OCPRE_IDX_COUNT_CLK);
  endfunction

  logic                    setup_phase;
  logic                    access_phase;
  logic                    wr_fire;
  logic                    known;
  logic [7:0]              wbyte;
  logic [7:0]              qual_reg;
  logic [7:0]              pclk_reg;
  logic [OCPRE_PTR_W-1:0]  ptr_reg;
  logic [OCPRE_CNT_W-1:0]  count_reg;
  logic [OCPRE_CNT_W-1:0]  preset_ram [OCPRE_DEPTH];
  logic [OCPRE_CNT_W-1:0]  preset_out;
  logic [OCPRE_DATA_W-1:0] prdata_reg;
  logic                    err_reg;
  logic                    sense_rd_reg;
  logic [OCPRE_SENSE_W-1:0] sense_bits;
  logic [OCPRE_SENSE_W-1:0] sense_reg;

  assign setup_phase  = psel && !penable;
  assign access_phase = psel && penable;
  assign known        = idx_known(paddr);
  // Read data is captured in setup, so every access ends in one access cycle
  assign pready       = access_phase;
  assign wr_fire      = access_phase && pwrite && known;
  assign wbyte        = pwdata[7:0];
  assign preset_out   = preset_ram[ptr_reg];

  assign sense_bits = {count_reg[OCPRE_SENSE_SRC2], count_reg[OCPRE_SENSE_SRC1], count_reg[OCPRE_SENSE_SRC0]};

  // ==========================================================
  // Control registers
  // qualifier control write
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      qual_reg <= OCPRE_QUAL_RST;
    else if (wr_fire && idx_hit(paddr, OCPRE_IDX_QUAL_CTRL))
      qual_reg <= wbyte;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      pclk_reg <= OCPRE_PCLK_RST;
    else if (wr_fire && idx_hit(paddr, OCPRE_IDX_PTR_CLK_CTL))
      pclk_reg <= wbyte;
  end

  assign dual_qualifier_select  = qual_reg[OCPRE_QUAL_DUAL_BIT];
  assign pointer_load_mode_n    = qual_reg[OCPRE_QUAL_LDMODE_BIT];
  assign pointer_clock_enable_n = pclk_reg[OCPRE_PCLK_EN_N_BIT];

  // ==========================================================
  // Address pointer
  // Strobes are ignored while the pointer clock is disabled
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      ptr_reg <= OCPRE_PTR_RST;
    else if (wr_fire && idx_hit(paddr, OCPRE_IDX_PTR_STROBE) && !pointer_clock_enable_n)
    begin
      if (!pointer_load_mode_n)
        ptr_reg <= wbyte[OCPRE_PTR_W-1:0];
      else
        ptr_reg <= ptr_reg + 4'h1;
    end
  end

  assign pointer_value = ptr_reg;

  // ==========================================================
  // Preset RAM, no reset as in the original part
  // store inverted pattern
  always_ff @(posedge clk)
  begin
    if (wr_fire && idx_hit(paddr, OCPRE_IDX_RAM_LOW))
      preset_ram[ptr_reg][7:0] <= ~wbyte;
    else if (wr_fire && idx_hit(paddr, OCPRE_IDX_RAM_HIGH))
      preset_ram[ptr_reg][11:8] <= ~wbyte[3:0];
  end

  // ==========================================================
  // Event counter
  // twelve-bit up-counter
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      count_reg <= OCPRE_CNT_RST;
    else if (wr_fire && idx_hit(paddr, OCPRE_IDX_PRESET))
      count_reg <= preset_out;
    else if (wr_fire && idx_hit(paddr, OCPRE_IDX_COUNT_CLK))
      count_reg <= count_reg + 12'h001;
  end

  assign event_count_value = count_reg;

  // ==========================================================
  // Read path
  // sense lines gated by read
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      sense_rd_reg <= 1'b0;
      sense_reg    <= '0;
    end
    else
    begin
      sense_rd_reg <= setup_phase && !pwrite && idx_hit(paddr, OCPRE_IDX_SENSE);
      sense_reg    <= (setup_phase && !pwrite && idx_hit(paddr, OCPRE_IDX_SENSE)) ? sense_bits : '0;
    end
  end

  assign trigger_status_read = sense_rd_reg && access_phase;
  assign counter_sense_lines = sense_reg;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      prdata_reg <= '0;
      err_reg    <= 1'b0;
    end
    else if (setup_phase)
    begin
      err_reg    <= !known;
      prdata_reg <= '0;
      if (!pwrite)
      begin
        if (idx_hit(paddr, OCPRE_IDX_SENSE))
          prdata_reg[OCPRE_SENSE_LSB +: OCPRE_SENSE_W] <= sense_bits;
        else if (idx_hit(paddr, OCPRE_IDX_PTR_STATUS))
          prdata_reg[OCPRE_PTR_W-1:0] <= ptr_reg;
        else if (idx_hit(paddr, OCPRE_IDX_QUAL_CTRL))
          prdata_reg[7:0] <= qual_reg;
        else if (idx_hit(paddr, OCPRE_IDX_PTR_CLK_CTL))
          prdata_reg[7:0] <= pclk_reg;
        else if (idx_hit(paddr, OCPRE_IDX_COUNT))
          prdata_reg[OCPRE_CNT_W-1:0] <= count_reg;
      end
    end
  end

  assign prdata  = prdata_reg;
  assign pslverr = access_phase && err_reg;

endmodule

// ==== ocpre_pkg.sv ====
// Constants for the preloadable occurrence counter block
package ocpre_pkg;

  // ==========================================================
  // Widths
  localparam int unsigned OCPRE_ADDR_W   = 12;
  localparam int unsigned OCPRE_DATA_W   = 32;
  localparam int unsigned OCPRE_CNT_W    = 12;
  localparam int unsigned OCPRE_PTR_W    = 4;
  localparam int unsigned OCPRE_DEPTH    = 16;
  localparam int unsigned OCPRE_SENSE_W  = 3;

  // ==========================================================
  // Register indices; byte address is four times the index
  localparam logic [7:0] OCPRE_IDX_PTR_STATUS  = 8'h04;
  localparam logic [7:0] OCPRE_IDX_SENSE       = 8'h0E;
  localparam logic [7:0] OCPRE_IDX_QUAL_CTRL   = 8'h10;
  localparam logic [7:0] OCPRE_IDX_PTR_CLK_CTL = 8'h11;
  localparam logic [7:0] OCPRE_IDX_PTR_STROBE  = 8'h12;
  localparam logic [7:0] OCPRE_IDX_RAM_LOW     = 8'h13;
  localparam logic [7:0] OCPRE_IDX_RAM_HIGH    = 8'h14;
  localparam logic [7:0] OCPRE_IDX_PRESET      = 8'h15;
  localparam logic [7:0] OCPRE_IDX_COUNT       = 8'h16;
  localparam logic [7:0] OCPRE_IDX_COUNT_CLK   = 8'h1F;

  // ==========================================================
  // Field positions
  localparam int unsigned OCPRE_QUAL_DUAL_BIT   = 7;
  localparam int unsigned OCPRE_QUAL_LDMODE_BIT = 0;
  localparam int unsigned OCPRE_PCLK_EN_N_BIT   = 0;
  localparam int unsigned OCPRE_SENSE_LSB       = 2;
  // Counter bits that reach the sense lines, one per counter slice
  localparam int unsigned OCPRE_SENSE_SRC0      = 11;
  localparam int unsigned OCPRE_SENSE_SRC1      = 6;
  localparam int unsigned OCPRE_SENSE_SRC2      = 1;

  // ==========================================================
  // Values after reset
  localparam logic [7:0]  OCPRE_QUAL_RST  = 8'h00;
  localparam logic [7:0]  OCPRE_PCLK_RST  = 8'h01;
  localparam logic [11:0] OCPRE_CNT_RST   = 12'h000;
  localparam logic [3:0]  OCPRE_PTR_RST   = 4'h0;

endpackage

// ==== ocpre_props.sv ====
// Assertions on the ports of the occurrence counter
`timescale 1ns/100ps
module ocpre_props
(
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        dual_qualifier_select,
  input wire logic        pointer_load_mode_n,
  input wire logic        pointer_clock_enable_n,
  input wire logic        trigger_status_read,
  input wire logic [2:0]  counter_sense_lines,
  input wire logic [11:0] event_count_value,
  input wire logic [3:0]  pointer_value
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ==========================================
  // Accepted write to one byte address
  sequence s_wr(logic [11:0] a);
    psel && penable && pwrite && paddr == a;
  endsequence
  a_status_strobe: assert property (trigger_status_read == (psel && penable && !pwrite && paddr == 12'h038))
    else $error("status strobe wrong");
  a_sense_idle: assert property (!trigger_status_read |-> counter_sense_lines == 3'h0)
    else $error("sense lines driven idle");
  a_sense_order: assert property (trigger_status_read |-> prdata[4:2] == counter_sense_lines
    && counter_sense_lines == {event_count_value[1], event_count_value[6], event_count_value[11]}) else $error("sense order");
  a_count_step: assert property (s_wr(12'h07C) |=> event_count_value == $past(event_count_value) + 12'h001)
    else $error("count step");
  a_qual_set: assert property (s_wr(12'h040) |=> dual_qualifier_select == $past(pwdata[7])
    && pointer_load_mode_n == $past(pwdata[0])) else $error("qualifier control");
  a_enable_set: assert property (s_wr(12'h044) |=> pointer_clock_enable_n == $past(pwdata[0]))
    else $error("pointer enable");
  a_ptr_load: assert property (s_wr(12'h048) ##0 !pointer_clock_enable_n && !pointer_load_mode_n
    |=> pointer_value == $past(pwdata[3:0])) else $error("pointer load");
  a_ptr_locked: assert property (s_wr(12'h048) ##0 pointer_clock_enable_n |=> $stable(pointer_value))
    else $error("pointer moved");
endmodule
bind ocpre_core ocpre_props i_props (.*);

// ==== ocpre_host.sv ====
// Host model: APB master that issues the strobes
`timescale 1ns/100ps
module ocpre_host
(
  input  wire logic        clk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata
);
  logic [31:0] rdat;
  logic        rerr;
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released write data lines show garbage, not old data
    pwdata <= ~d;
  endtask
endmodule

// ==== occurrence_counter_preload_test.sv ====
// Self-checking bench for the occurrence counter
`timescale 1ns/100ps
module occurrence_counter_preload_test
  import ocpre_pkg::*;
;
  logic        clk, sys_rst, psel, penable, pwrite, pready, pslverr, trigger_status_read;
  logic        dual_qualifier_select, pointer_load_mode_n, pointer_clock_enable_n;
  logic [11:0] paddr, event_count_value;
  logic [31:0] pwdata, prdata;
  logic [2:0]  counter_sense_lines;
  logic [3:0]  pointer_value;
  int          error_cnt, samples_checked, seed, i, n, m_cnt;
  logic [11:0] pat [8] = '{12'h515, 12'hAA8, 12'h555, 12'hAE8, 12'h517, 12'hAAA, 12'h557, 12'hAEA};
  ocpre_core i_dut (.*);
  ocpre_host i_host (.*);
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Random upper bits must be ignored
  task automatic wr(input logic [7:0] idx, input logic [7:0] b);
    logic [31:0] r;
    r = $random(seed);
    i_host.xfer(1'b1, idx, {r[31:8], b});
  endtask
  task automatic rd(input logic [7:0] idx);
    i_host.xfer(1'b0, idx, 32'h0000_0000);
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    summarize();
  end
  initial
  begin
    seed = 32'h592a_14d7;
    sys_rst = 1'b1;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    rd(OCPRE_IDX_COUNT);
    chk(i_host.rdat, 32'h0000_0000);
    rd(8'h3F);
    chk(i_host.rerr, 1'b1);
    wr(OCPRE_IDX_QUAL_CTRL, 8'h80);
    wr(OCPRE_IDX_PTR_CLK_CTL, 8'h00);
    // Control outputs change on the accepting edge only after xfer has returned; this extra edge is needed
    @(posedge clk);
    chk({dual_qualifier_select, pointer_load_mode_n, pointer_clock_enable_n}, 3'b100);
    $display("test setup done");
    for (i = 0; i < 16; i++)
    begin
      wr(OCPRE_IDX_PTR_STROBE, i[7:0]);
      wr(OCPRE_IDX_RAM_LOW, ~pat[i % 8][7:0]);
      wr(OCPRE_IDX_RAM_HIGH, {4'h0, ~pat[i % 8][11:8]});
    end
    for (i = 0; i < 16; i++)
    begin
      wr(OCPRE_IDX_PTR_STROBE, i[7:0]);
      wr(OCPRE_IDX_PRESET, 8'h00);
      m_cnt = pat[i % 8];
      rd(OCPRE_IDX_SENSE);
      chk(i_host.rdat & 32'h0000_001C, (i % 8) * 4);
      chk(i_host.rdat[4:2], {m_cnt[1], m_cnt[6], m_cnt[11]});
      rd(OCPRE_IDX_COUNT);
      chk(i_host.rdat, m_cnt);
      chk(event_count_value, m_cnt);
      chk(pointer_value, i[3:0]);
    end
    $display("test preset table done");
    wr(OCPRE_IDX_PTR_STROBE, 8'h00);
    wr(OCPRE_IDX_RAM_LOW, 8'h00);
    wr(OCPRE_IDX_RAM_HIGH, 8'h00);
    wr(OCPRE_IDX_PRESET, 8'h00);
    n = 1 + ($random(seed) & 15);
    repeat (n) wr(OCPRE_IDX_COUNT_CLK, 8'h00);
    rd(OCPRE_IDX_COUNT);
    chk(i_host.rdat, (12'hFFF + n) & 12'hFFF);
    $display("test count wrap done");
    wr(OCPRE_IDX_QUAL_CTRL, 8'h81);
    wr(OCPRE_IDX_PTR_STROBE, 8'h07);
    wr(OCPRE_IDX_PTR_CLK_CTL, 8'h01);
    wr(OCPRE_IDX_PTR_STROBE, 8'h07);
    rd(OCPRE_IDX_PTR_STATUS);
    chk(i_host.rdat[3:0], 4'h1);
    $display("test pointer modes done");
    summarize();
  end
endmodule
